// ==== rtl/sfpo_defines.vh ====
// Constants for the scaled flow pulse output block.
// Assumes inclusion by its bare name from the top-level design file.
`ifndef SFPO_DEFINES_VH
`define SFPO_DEFINES_VH

// Register numbers
`define SFPO_REG_UNIT_CODE 16'h0025
`define SFPO_REG_SHAPE 16'h0055
`define SFPO_REG_FACTOR 16'h0147
`define SFPO_REG_DURATION 16'h0149

// Output shape values
`define SFPO_SHAPE_FIXED 16'h0000
`define SFPO_SHAPE_SQUARE 16'h0001

// Closure duration, counted in 10 us steps
`define SFPO_DUR_STEP_NS 10000
`define SFPO_DUR_MIN 32'h0000000A
`define SFPO_DUR_MAX 32'h0000FDE8
`define SFPO_DUR_RESET 32'h00000032

// Clock and frequency ceilings
`define SFPO_CLK_PERIOD_NS 5
`define SFPO_CYC_PER_STEP (`SFPO_DUR_STEP_NS / `SFPO_CLK_PERIOD_NS)
`define SFPO_CLK_HZ 200000000
`define SFPO_FULL_SCALE_HZ 10000
`define SFPO_ABS_MAX_HZ 11000
`define SFPO_SAFE_MAX_HZ 5000
`define SFPO_MIN_PER_NORMAL ((`SFPO_CLK_HZ + `SFPO_ABS_MAX_HZ - 1) / `SFPO_ABS_MAX_HZ)
`define SFPO_MIN_PER_SAFE ((`SFPO_CLK_HZ + `SFPO_SAFE_MAX_HZ - 1) / `SFPO_SAFE_MAX_HZ)

// Factor unit codes
`define SFPO_UNIT_GAL 16'h0028
`define SFPO_UNIT_LITER 16'h0029
`define SFPO_UNIT_IMP_GAL 16'h002A
`define SFPO_UNIT_CUBIC_M 16'h002B
`define SFPO_UNIT_FEET 16'h002C
`define SFPO_UNIT_METERS 16'h002D
`define SFPO_UNIT_BBL42 16'h002E
`define SFPO_UNIT_KG 16'h003D
`define SFPO_UNIT_TONNE 16'h003E
`define SFPO_UNIT_POUND 16'h003F
`define SFPO_UNIT_SHORT_TON 16'h0040
`define SFPO_UNIT_CUBIC_FT 16'h0070
`define SFPO_UNIT_CUBIC_CM 16'h00F6
`define SFPO_UNIT_BBL31 16'h00F7
`define SFPO_UNIT_MGAL 16'h00F9
`define SFPO_UNIT_SPECIAL 16'h00FD

`endif

// ==== rtl/sfpo_scaler.v ====
// Quantity accumulator: turns flow increments into pulse requests.
// Assumes flow increments and factor come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module sfpo_scaler #(
	parameter W = 32
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire [W-1:0] factor_in,
	input wire flow_valid_in,
	input wire [W-1:0] flow_inc_in,
	output reg req_out
);
	reg [W:0] acc;
	reg [W:0] sum;

	always @* begin
		sum = acc + (flow_valid_in ? {1'b0, flow_inc_in} : {(W+1){1'b0}});
	end

	// Remainder kept after each crossing so no quantity is dropped
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			acc <= {(W+1){1'b0}};
			req_out <= 1'b0;
		end else if (factor_in == {W{1'b0}}) begin
			acc <= {(W+1){1'b0}};
			req_out <= 1'b0;
		end else if (sum >= {1'b0, factor_in}) begin
			acc <= sum - {1'b0, factor_in};
			req_out <= 1'b1;
		end else begin
			acc <= sum;
			req_out <= 1'b0;
		end
	end
endmodule // sfpo_scaler
`default_nettype wire

// ==== rtl/sfpo_top.v ====
// Scaled flow pulse output: register file, owed-pulse count and pulse shaper.
// Assumes flow increments arrive on core_clk_in; register port is single-cycle.
// Behaviour
// - The shape register picks fixed closure (0, reset value) or square wave (1).
// - In square wave the closure lasts half the current output period.
// - The closure duration only acts while the shape is fixed closure.
// - Closure duration is accepted from 0.1 ms to 650 ms and resets to 0.5 ms.
// - In fixed closure the period is never shorter than twice the closure duration.
// - Output rate never exceeds the 11000 Hz absolute ceiling.
// - With the intrinsically safe option the ceiling is 5000 Hz.
// - One closure is emitted per factor's worth of quantity.
// - The factor spans from one pulse per day to 10000 Hz rates.
// - The unit code is read only and carries the volume codes.
// - Mass, length and special units have their own codes.
`timescale 1ns/10ps
`default_nettype none
`include "sfpo_defines.vh"
module sfpo_top #(
	parameter SAFE_OUTPUT = 0,
	parameter OWED_W = 16
) (
	input wire core_clk_in,
	input wire arst_n_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [15:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire flow_valid_in,
	input wire [31:0] flow_inc_in,
	input wire [15:0] flow_unit_code_in,
	output reg [31:0] reg_rdata_out,
	output reg reg_ack_out,
	output reg pulse_out,
	output reg owed_overflow_out
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_HIGH = 3'b010;
	localparam [2:0] ST_LOW = 3'b100;
	localparam [31:0] MIN_PER = (SAFE_OUTPUT != 0) ? `SFPO_MIN_PER_SAFE : `SFPO_MIN_PER_NORMAL;
	localparam [31:0] CYC_STEP = `SFPO_CYC_PER_STEP;

	reg rst_meta;
	reg rst_n;
	reg [15:0] shape;
	reg [31:0] factor;
	reg [31:0] duration;
	reg [15:0] unit_code;
	reg [OWED_W-1:0] owed;
	reg [2:0] state;
	reg [31:0] per_cnt;
	reg [31:0] req_gap;
	reg [31:0] last_gap;
	reg [31:0] width_cyc;
	reg [31:0] high_len;
	reg [31:0] min_period;
	reg [31:0] next_rdata;
	reg [31:0] wdur;
	wire req;
	wire start;
	wire square;

	// Reset release through two flops
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	sfpo_scaler #(
		.W(32)
	) u_scaler (
		.clk_in(core_clk_in),
		.rst_n_in(rst_n),
		.factor_in(factor),
		.flow_valid_in(flow_valid_in),
		.flow_inc_in(flow_inc_in),
		.req_out(req)
	);

	assign square = (shape == `SFPO_SHAPE_SQUARE);

	// Out-of-range durations are clamped rather than refused
	always @* begin
		if (reg_wdata_in < `SFPO_DUR_MIN)
			wdur = `SFPO_DUR_MIN;
		else if (reg_wdata_in > `SFPO_DUR_MAX)
			wdur = `SFPO_DUR_MAX;
		else
			wdur = reg_wdata_in;
	end

	// Register file
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			shape <= `SFPO_SHAPE_FIXED;
			factor <= 32'h00000000;
			duration <= `SFPO_DUR_RESET;
			unit_code <= `SFPO_UNIT_GAL;
		end else begin
			unit_code <= flow_unit_code_in;
			if (reg_wr_in) begin
				case (reg_addr_in)
					`SFPO_REG_SHAPE: begin
						if (reg_wdata_in[15:0] == `SFPO_SHAPE_SQUARE)
							shape <= `SFPO_SHAPE_SQUARE;
						else
							shape <= `SFPO_SHAPE_FIXED;
					end
					`SFPO_REG_FACTOR: factor <= reg_wdata_in;
					`SFPO_REG_DURATION: duration <= wdur;
					default: begin
					end
				endcase
			end
		end
	end

	always @* begin
		case (reg_addr_in)
			`SFPO_REG_UNIT_CODE: next_rdata = {16'h0000, unit_code};
			`SFPO_REG_SHAPE: next_rdata = {16'h0000, shape};
			`SFPO_REG_FACTOR: next_rdata = factor;
			`SFPO_REG_DURATION: next_rdata = duration;
			default: next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_out <= 32'h00000000;
			reg_ack_out <= 1'b0;
		end else begin
			reg_ack_out <= reg_rd_in | reg_wr_in;
			if (reg_rd_in)
				reg_rdata_out <= next_rdata;
		end
	end

	// Measured spacing of requests sets the square-wave period
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			req_gap <= 32'h00000000;
			last_gap <= 32'h00000000;
		end else if (req) begin
			req_gap <= 32'h00000001;
			last_gap <= req_gap;
		end else if (req_gap != 32'hFFFFFFFF) begin
			req_gap <= req_gap + 32'h00000001;
		end
	end

	// Shaping lengths, all in clock cycles
	always @* begin
		width_cyc = duration * CYC_STEP;
		if (square) begin
			min_period = (last_gap > MIN_PER) ? last_gap : MIN_PER;
			high_len = {1'b0, min_period[31:1]};
		end else begin
			high_len = width_cyc;
			min_period = ({width_cyc[30:0], 1'b0} > MIN_PER) ? {width_cyc[30:0], 1'b0} : MIN_PER;
		end
	end

	assign start = (owed != {OWED_W{1'b0}}) && (state != ST_HIGH) && (per_cnt >= min_period);

	// Owed pulses; a request in the same cycle as a start keeps the count
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			owed <= {OWED_W{1'b0}};
			owed_overflow_out <= 1'b0;
		end else begin
			if (req && !start) begin
				if (owed == {OWED_W{1'b1}})
					owed_overflow_out <= 1'b1;
				else
					owed <= owed + {{(OWED_W-1){1'b0}}, 1'b1};
			end else if (start && !req) begin
				owed <= owed - {{(OWED_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Pulse shaper
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			per_cnt <= 32'hFFFFFFFF;
			pulse_out <= 1'b0;
		end else begin
			if (per_cnt != 32'hFFFFFFFF)
				per_cnt <= per_cnt + 32'h00000001;
			case (state)
				ST_IDLE,
				ST_LOW: begin
					if (start) begin
						state <= ST_HIGH;
						per_cnt <= 32'h00000001;
						pulse_out <= 1'b1;
					end
				end
				ST_HIGH: begin
					if (per_cnt >= high_len) begin
						state <= ST_LOW;
						pulse_out <= 1'b0;
					end
				end
				default: begin
					state <= ST_IDLE;
					pulse_out <= 1'b0;
				end
			endcase
		end
	end
endmodule // sfpo_top
`default_nettype wire

// ==== test/sfpo_chk.sv ====
// Port checker for sfpo_top.
// Assumes binding to each sfpo_top instance.
`timescale 1ns/10ps
`default_nettype none
module sfpo_chk #(
	parameter SAFE_OUTPUT = 0
) (
	input wire core_clk_in,
	input wire arst_n_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [15:0] reg_addr_in,
	input wire [31:0] reg_rdata_out,
	input wire reg_ack_out,
	input wire pulse_out,
	input wire owed_overflow_out
);
	logic [15:0] gap;
	logic prev;
	wire [15:0] minp = SAFE_OUTPUT ? 16'h9C40 : 16'h4706;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);
	// Saturates so the first rise after reset always passes
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prev <= 1'b0;
			gap <= 16'hFFFF;
		end else begin
			prev <= pulse_out;
			gap <= (pulse_out && !prev) ? 16'h0001 : gap + {15'h0, gap != 16'hFFFF};
		end
	end
	chk_ack_after_req: assert property ((reg_wr_in || reg_rd_in) |=> reg_ack_out)
		else $error("ack missing");
	chk_no_stray_ack: assert property (!(reg_wr_in || reg_rd_in) |=> !reg_ack_out)
		else $error("stray ack");
	chk_shape_one_bit: assert property (reg_rd_in && reg_addr_in == 16'h0055 |=>
		reg_rdata_out[31:1] == 31'h0) else $error("shape wide");
	chk_unit_upper_zero: assert property (reg_rd_in && reg_addr_in == 16'h0025 |=>
		reg_rdata_out[31:16] == 16'h0) else $error("unit wide");
	chk_dur_in_range: assert property (reg_rd_in && reg_addr_in == 16'h0149 |=>
		reg_rdata_out inside {[32'hA:32'hFDE8]}) else $error("duration range");
	chk_unmapped_zero: assert property (reg_rd_in &&
		!(reg_addr_in inside {16'h25, 16'h55, 16'h147, 16'h149}) |=> reg_rdata_out == 32'h0)
		else $error("unmapped data");
	chk_rise_spacing: assert property ($rose(pulse_out) |-> gap >= minp)
		else $error("rate ceiling");
	chk_overflow_sticky: assert property (owed_overflow_out |=> owed_overflow_out)
		else $error("overflow dropped");
endmodule // sfpo_chk
bind sfpo_top sfpo_chk #(.SAFE_OUTPUT(SAFE_OUTPUT)) chk_i (.*);
`default_nettype wire

// ==== test/sfpo_counter.sv ====
// External counter input: counts closures, measures closure length.
// Assumes the pulse is sampled on the device clock.
`timescale 1ns/10ps
`default_nettype none
module sfpo_counter (
	input wire logic clk_in,
	input wire logic pulse_in,
	output logic [31:0] count_out = 32'h0,
	output logic [31:0] high_out = 32'h0
);
	logic [31:0] run = 32'h0;
	always @(posedge clk_in) begin
		if (pulse_in) begin
			run <= run + 32'h1;
			count_out <= count_out + {31'h0, run == 32'h0};
		end else if (run != 32'h0) begin
			high_out <= run;
			run <= 32'h0;
		end
	end
endmodule // sfpo_counter
`default_nettype wire

// ==== test/sfpo_top_tb.sv ====
// Testbench for sfpo_top: registers, fixed closure, square wave.
// Assumes the design under rtl/ and the counter model.
`timescale 1ns/10ps
`default_nettype none
module sfpo_top_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic fv = 1'b0;
	logic [15:0] addr = 16'h0;
	logic [15:0] unit = 16'h29;
	logic [31:0] wdata = 32'h0;
	logic [31:0] inc = 32'h0;
	logic [15:0] codes [16] = '{16'h28, 16'h29, 16'h2A, 16'h2B, 16'h2E, 16'h70, 16'hF6,
		16'hF7, 16'hF9, 16'h3D, 16'h3E, 16'h3F, 16'h40, 16'h2C, 16'h2D, 16'hFD};
	wire [31:0] rdata, cnt, high;
	wire ack, pulse, ovf;
	int fail_count = 0;
	int total_checks = 0;
	sfpo_top dut (.core_clk_in(clk), .arst_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .flow_valid_in(fv), .flow_inc_in(inc),
		.flow_unit_code_in(unit), .reg_rdata_out(rdata), .reg_ack_out(ack),
		.pulse_out(pulse), .owed_overflow_out(ovf));
	sfpo_counter far (.clk_in(clk), .pulse_in(pulse), .count_out(cnt), .high_out(high));
	task automatic ck(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(negedge clk);
		wr = w;
		rd = !w;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
		ck(ack === 1'b1 && ovf === 1'b0, "no ack");
	endtask
	task automatic rchk(input logic [15:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		ck(rdata === e, "read value");
	endtask
	task automatic flow(input logic [31:0] v);
		@(negedge clk);
		fv = 1'b1;
		inc = v;
		@(negedge clk);
		fv = 1'b0;
	endtask
	task automatic t_regs;
		rchk(16'h0055, 32'h0);
		rchk(16'h0149, 32'h32);
		rchk(16'h0147, 32'h0);
		rchk(16'h0030, 32'h0);
		acc(1'b1, 16'h0149, 32'h5);
		rchk(16'h0149, 32'hA);
		acc(1'b1, 16'h0149, 32'h11170);
		rchk(16'h0149, 32'hFDE8);
		acc(1'b1, 16'h0055, 32'h2);
		rchk(16'h0055, 32'h0);
		acc(1'b1, 16'h0025, 32'h0);
		foreach (codes[i]) begin
			unit = codes[i];
			repeat (2) @(negedge clk);
			rchk(16'h0025, {16'h0, codes[i]});
		end
	endtask
	task automatic t_fixed;
		int n;
		acc(1'b1, 16'h0149, 32'hA);
		acc(1'b1, 16'h0147, 32'hA);
		flow(32'h7);
		repeat (5) @(negedge clk);
		ck(pulse === 1'b0, "early pulse");
		flow(32'h3);
		@(negedge clk);
		ck(pulse === 1'b0, "pulse too soon");
		@(negedge clk);
		ck(pulse === 1'b1, "no pulse");
		n = 0;
		while (pulse !== 1'b0 && n < 20100) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		ck(high === 32'h4E20 && cnt === 32'h1, "fixed closure");
		// Lets the fixed-mode period run out before the shape changes
		repeat (20000) @(negedge clk);
	endtask
	task automatic t_square;
		acc(1'b1, 16'h0055, 32'h1);
		repeat (2) begin
			flow(32'hA);
			repeat (18998) @(negedge clk);
		end
		ck(high === 32'h251C && cnt === 32'h3, "square duty");
	endtask
	task automatic close_out;
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_regs();
		t_fixed();
		t_square();
		close_out();
	end
	initial begin
		repeat (120000) @(posedge clk);
		fail_count++;
		close_out();
	end
endmodule // sfpo_top_tb
`default_nettype wire
